// ### sdp_ident_chk.sv
/*
  Payload identifier packet checker for one received stream.
  Assumes words, line number and scan type come from receive logic on i_clk.
*/
`timescale 1ns/1ns
module sdp_ident_chk (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_clr,
  input  wire logic        i_vld,
  input  wire logic [9:0]  i_word,
  input  wire logic [10:0] i_line,
  input  wire logic        i_interlaced,
  output logic             o_ok,
  output logic             o_sum_fault,
  output logic             o_par_fault,
  output logic             o_line_right
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADF1, ST_ADF2, ST_DID, ST_SDID, ST_DC, ST_UDW, ST_CSUM
  } sdp_id_st_t;

  function automatic logic sdp_par_bad(input logic [9:0] w);
    sdp_par_bad = (w[8] != ^w[7:0]) || (w[9] == w[8]);
  endfunction : sdp_par_bad

  sdp_id_st_t st_q;
  sdp_id_st_t st_d;
  logic [1:0] cnt_q;
  logic [8:0] sum_q;
  logic       perr_q;
  logic       seen_q;

  wire        at_csum  = i_vld && (st_q == ST_CSUM);
  wire        csum_bad = (i_word[8:0] != sum_q) || (i_word[9] == i_word[8]);
  wire        at_f1    = (i_line == sdp_pkg::ID_LINE_F1);
  wire        at_f2    = (i_line == sdp_pkg::ID_LINE_F2);

  always_comb
  begin
    st_d = st_q;
    if (i_vld)
    begin
      case (st_q)
        ST_IDLE: if (i_word == sdp_pkg::ADF_ZERO) st_d = ST_ADF1;
        ST_ADF1:
        begin
          if (i_word == sdp_pkg::ADF_ONES) st_d = ST_ADF2;
          else if (i_word != sdp_pkg::ADF_ZERO) st_d = ST_IDLE;
        end
        ST_ADF2: st_d = (i_word == sdp_pkg::ADF_ONES) ? ST_DID : ST_IDLE;
        ST_DID:  st_d = (i_word == sdp_pkg::ID_DID) ? ST_SDID : ST_IDLE;
        ST_SDID: st_d = (i_word == sdp_pkg::ID_SDID) ? ST_DC : ST_IDLE;
        ST_DC:   st_d = ST_UDW;
        ST_UDW:  if (cnt_q == sdp_pkg::ID_UDW_LAST) st_d = ST_CSUM;
        ST_CSUM: st_d = ST_IDLE;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q   <= ST_IDLE;
      cnt_q  <= 2'h0;
      sum_q  <= 9'h000;
      perr_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= (st_q == ST_UDW && i_vld) ? cnt_q + 2'h1 : 2'h0;
      if (i_vld && st_q == ST_DID)
      begin
        sum_q  <= i_word[8:0];
        perr_q <= sdp_par_bad(i_word);
      end
      else if (i_vld && (st_q == ST_SDID || st_q == ST_DC || st_q == ST_UDW))
      begin
        sum_q  <= sum_q + i_word[8:0];
        perr_q <= perr_q | sdp_par_bad(i_word);
      end
    end
  end

  // Flags update once per accepted packet; loss of stream clears them
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ok         <= 1'b0;
      o_sum_fault  <= 1'b0;
      o_par_fault  <= 1'b0;
      o_line_right <= 1'b0;
      seen_q       <= 1'b0;
    end
    else if (i_clr)
    begin
      o_ok         <= 1'b0;
      o_sum_fault  <= 1'b0;
      o_par_fault  <= 1'b0;
      o_line_right <= 1'b0;
      seen_q       <= 1'b0;
    end
    else if (at_csum)
    begin
      o_ok        <= 1'b1;
      o_sum_fault <= csum_bad;
      o_par_fault <= perr_q;
      if (at_f1)
      begin
        seen_q       <= 1'b1;
        o_line_right <= ~i_interlaced;
      end
      else if (at_f2)
      begin
        seen_q       <= 1'b0;
        o_line_right <= i_interlaced & seen_q;
      end
      else
        o_line_right <= 1'b0;
    end
  end

  chk_ok_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_ok) |-> $past(at_csum && !i_clr))
    else $error("identifier valid rose without a full packet");

  chk_sum_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (at_csum && !i_clr && csum_bad) |=> o_sum_fault)
    else $error("checksum mismatch not flagged");

  chk_par_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (at_csum && !i_clr) |=> (o_par_fault == $past(perr_q)))
    else $error("parity flag does not follow packet parity");

  chk_line_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_line_right) |-> $past((at_f1 && !i_interlaced) || (at_f2 && i_interlaced)))
    else $error("line flag set on wrong line");

endmodule : sdp_ident_chk

// ### sdp_pkg.sv
/*
  Shared constants for the video PHY user-side port logic: register map,
  control fields, rate indices, ancillary identifier words and SD word
  expansion values. Assumes a single 125 MHz system clock.
*/
package sdp_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STAT     = 8'h04;
  localparam logic [7:0]  REG_TXW      = 8'h08;

  // Control register fields
  localparam int          CTRL_W       = 5;
  localparam int          CTRL_SD10    = 0;
  localparam int          CTRL_SDPORT  = 1;
  localparam int          CTRL_CRC_INS = 2;
  localparam int          CTRL_LN_INS  = 3;
  localparam int          CTRL_ID_INS  = 4;
  localparam logic [4:0]  CTRL_RST     = 5'h1C;

  // Rate scan bit positions and rate indices
  localparam int          RATE_SD      = 0;
  localparam int          RATE_HD      = 1;
  localparam int          RATE_3G      = 2;
  localparam logic [1:0]  RATE_IDX_MAX = 2'h2;

  // Payload identifier ancillary packet
  localparam logic [9:0]  ADF_ZERO     = 10'h000;
  localparam logic [9:0]  ADF_ONES     = 10'h3FF;
  localparam logic [9:0]  ID_DID       = 10'h241;
  localparam logic [9:0]  ID_SDID      = 10'h101;
  localparam logic [1:0]  ID_UDW_LAST  = 2'h3;
  localparam logic [10:0] ID_LINE_F1   = 11'h00A;
  localparam logic [10:0] ID_LINE_F2   = 11'h23C;

  // Word widths and 8-bit SD expansion
  localparam int          TX_W         = 20;
  localparam int          SD_W         = 10;
  localparam logic [7:0]  SD8_ONES     = 8'hFF;
  localparam logic [1:0]  SD8_LSB_TRS  = 2'h3;
  localparam logic [1:0]  SD8_LSB_PAD  = 2'h0;

  // Rate hunt dwell per candidate rate
  localparam int          DWELL_CYC    = 1024;

endpackage : sdp_pkg

// ### sdp_ports.sv
/*
  User-side port logic of a multi-rate serial video PHY: identifier status
  flags per stream, receive rate hunt, transmit parallel capture with SD
  10-bit pairing and 8-bit expansion, and an APB register file.
  Assumes receive words, line numbers and lock come from logic on i_clk;
  transmit clocks and data pins are asynchronous and slower than i_clk/2.
*/
`timescale 1ns/1ns
module sdp_ports #(
  parameter int DWELL = sdp_pkg::DWELL_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Receive side, logic on i_clk
  input  wire logic        i_rx_word_vld,
  input  wire logic [9:0]  i_rx_s1_word,
  input  wire logic [9:0]  i_rx_s2_word,
  input  wire logic [10:0] i_rx_s1_line,
  input  wire logic [10:0] i_rx_s2_line,
  input  wire logic        i_rx_interlaced,
  input  wire logic        i_rx_level_b,
  input  wire logic        i_rx_locked,
  input  wire logic [2:0]  i_rate_scan_en,
  output logic      [1:0]  o_rx_rate_sel,
  output logic             o_rx_hunting,
  output logic             o_ident_ok_s1,
  output logic             o_ident_sum_fault_s1,
  output logic             o_ident_par_fault_s1,
  output logic             o_ident_line_right_s1,
  output logic             o_ident_ok_s2,
  output logic             o_ident_sum_fault_s2,
  output logic             o_ident_par_fault_s2,
  output logic             o_ident_line_right_s2,
  // Transmit side pins, asynchronous
  input  wire logic        i_pdi_clk,
  input  wire logic        i_tx_half_clk,
  input  wire logic        i_sd_27m_clock,
  input  wire logic [19:0] i_tx_parallel_word,
  input  wire logic [9:0]  i_tx_sd_ten_bit_word,
  input  wire logic        i_trs_marker,
  input  wire logic        i_high_def_select,
  input  wire logic        i_level_b_select,
  input  wire logic        i_sd_eight_bit_select,
  output logic      [19:0] o_tx_word,
  output logic             o_tx_word_vld,
  output logic             o_tx_trs,
  output logic             o_tx_high_def,
  output logic             o_tx_level_b
);

  localparam int SYNC_W = 10 + sdp_pkg::TX_W + sdp_pkg::SD_W;
  localparam int DW     = $clog2(DWELL);

  function automatic logic [9:0] sdp_expand(input logic [9:0] w, input logic m);
    if (!m)
      sdp_expand = w;
    else if (w[9:2] == sdp_pkg::SD8_ONES)
      sdp_expand = {w[9:2], sdp_pkg::SD8_LSB_TRS};
    else
      sdp_expand = {w[9:2], sdp_pkg::SD8_LSB_PAD};
  endfunction : sdp_expand

  function automatic logic [1:0] sdp_next_rate(input logic [1:0] cur, input logic [2:0] en);
    logic [1:0] c;
    logic       f;
    c = cur;
    f = 1'b0;
    sdp_next_rate = cur;
    for (int k = 0; k < 3; k++)
    begin
      c = (c == sdp_pkg::RATE_IDX_MAX) ? 2'h0 : c + 2'h1;
      if (!f && en[c])
      begin
        sdp_next_rate = c;
        f = 1'b1;
      end
    end
  endfunction : sdp_next_rate

  // Synchronised pin levels
  logic [SYNC_W-1:0] sync_s;
  logic              pdi_s;
  logic              half_s;
  logic              c27_s;
  logic              hd_s;
  logic              lvb_s;
  logic              sd8_s;
  logic              trs_s;
  logic [2:0]        rate_s;
  logic [19:0]       pdw_s;
  logic [9:0]        sdw_s;

  sdp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({i_pdi_clk, i_tx_half_clk, i_sd_27m_clock, i_high_def_select,
                i_level_b_select, i_sd_eight_bit_select, i_trs_marker,
                i_rate_scan_en, i_tx_parallel_word, i_tx_sd_ten_bit_word}),
    .o_q      (sync_s)
  );

  assign {pdi_s, half_s, c27_s, hd_s, lvb_s, sd8_s, trs_s, rate_s, pdw_s, sdw_s} = sync_s;

  // One more stage for edge finding; data kept aligned with the clock level
  logic        pdi_d_q;
  logic        half_d_q;
  logic        c27_d_q;
  logic        trs_d_q;
  logic [19:0] pdw_d_q;
  logic [9:0]  sdw_d_q;
  logic [4:0]  ctrl_q;
  logic [9:0]  low_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pdi_d_q  <= 1'b0;
      half_d_q <= 1'b0;
      c27_d_q  <= 1'b0;
      trs_d_q  <= 1'b0;
      pdw_d_q  <= 20'h00000;
      sdw_d_q  <= 10'h000;
    end
    else
    begin
      pdi_d_q  <= pdi_s;
      half_d_q <= half_s;
      c27_d_q  <= c27_s;
      trs_d_q  <= trs_s;
      pdw_d_q  <= pdw_s;
      sdw_d_q  <= sdw_s;
    end
  end

  // Transmit selection
  wire        pdi_rise = pdi_s & ~pdi_d_q;
  wire        c27_rise = c27_s & ~c27_d_q;
  wire        sd_mode  = ~hd_s;
  wire        sd10     = sd_mode & ctrl_q[sdp_pkg::CTRL_SD10];
  wire        sdport   = ctrl_q[sdp_pkg::CTRL_SDPORT];
  wire        ins_any  = |ctrl_q[sdp_pkg::CTRL_ID_INS:sdp_pkg::CTRL_CRC_INS];
  wire        sd_edge  = sdport ? c27_rise : pdi_rise;
  wire [9:0]  sd_src   = sdport ? sdw_d_q : pdw_d_q[9:0];
  wire [9:0]  sd_exp   = sdp_expand(sd_src, sd8_s);
  wire [9:0]  hi_exp   = sdp_expand(pdw_d_q[19:10], sd8_s & sd_mode);
  wire [9:0]  lo_exp   = sdp_expand(pdw_d_q[9:0], sd8_s & sd_mode);
  wire        take20   = ~sd10 & pdi_rise;
  wire        first10  = half_d_q;
  wire        take10   = sd10 & sd_edge;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_tx_word     <= 20'h00000;
      o_tx_word_vld <= 1'b0;
      o_tx_trs      <= 1'b0;
      o_tx_high_def <= 1'b0;
      o_tx_level_b  <= 1'b0;
      low_q         <= 10'h000;
    end
    else
    begin
      o_tx_word_vld <= (take20 | (take10 & ~first10));
      o_tx_trs      <= take20 & trs_d_q & hd_s & ins_any;
      if (take20)
      begin
        o_tx_word     <= {hi_exp, lo_exp};
        o_tx_high_def <= hd_s;
        o_tx_level_b  <= lvb_s;
      end
      else if (take10 && first10)
        low_q <= sd_exp;
      else if (take10)
      begin
        o_tx_word     <= {sd_exp, low_q};
        o_tx_high_def <= hd_s;
        o_tx_level_b  <= lvb_s;
      end
    end
  end

  // Rate hunt
  logic [DW-1:0] dwell_q;
  wire           dwell_end = (dwell_q == DW'(DWELL - 1));

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dwell_q       <= '0;
      o_rx_rate_sel <= 2'h0;
      o_rx_hunting  <= 1'b0;
    end
    else
    begin
      o_rx_hunting <= ~i_rx_locked & (|rate_s);
      if (i_rx_locked)
        dwell_q <= '0;
      else if (dwell_end)
      begin
        dwell_q       <= '0;
        o_rx_rate_sel <= sdp_next_rate(o_rx_rate_sel, rate_s);
      end
      else
        dwell_q <= dwell_q + DW'(1);
    end
  end

  // Identifier checkers, stream two only alive for level-B
  wire clr_s1 = ~i_rx_locked;
  wire clr_s2 = ~i_rx_locked | ~i_rx_level_b;

  sdp_ident_chk u_id_s1 (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_clr        (clr_s1),
    .i_vld        (i_rx_word_vld),
    .i_word       (i_rx_s1_word),
    .i_line       (i_rx_s1_line),
    .i_interlaced (i_rx_interlaced),
    .o_ok         (o_ident_ok_s1),
    .o_sum_fault  (o_ident_sum_fault_s1),
    .o_par_fault  (o_ident_par_fault_s1),
    .o_line_right (o_ident_line_right_s1)
  );

  sdp_ident_chk u_id_s2 (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_clr        (clr_s2),
    .i_vld        (i_rx_word_vld & i_rx_level_b),
    .i_word       (i_rx_s2_word),
    .i_line       (i_rx_s2_line),
    .i_interlaced (i_rx_interlaced),
    .o_ok         (o_ident_ok_s2),
    .o_sum_fault  (o_ident_sum_fault_s2),
    .o_par_fault  (o_ident_par_fault_s2),
    .o_line_right (o_ident_line_right_s2)
  );

  // APB slave: one wait state, answer on the second access cycle
  wire        acc      = i_psel & i_penable;
  wire        ans      = acc & ~o_pready;
  wire        hit_ctrl = (i_paddr == sdp_pkg::REG_CTRL);
  wire        hit_stat = (i_paddr == sdp_pkg::REG_STAT);
  wire        hit_txw  = (i_paddr == sdp_pkg::REG_TXW);
  wire        mapped   = hit_ctrl | hit_stat | hit_txw;
  wire        wr_ctrl  = acc & o_pready & i_pwrite & hit_ctrl;
  wire [3:0]  id1      = {o_ident_line_right_s1, o_ident_par_fault_s1,
                          o_ident_sum_fault_s1, o_ident_ok_s1};
  wire [3:0]  id2      = {o_ident_line_right_s2, o_ident_par_fault_s2,
                          o_ident_sum_fault_s2, o_ident_ok_s2};
  wire [31:0] stat_w   = {18'h00000, o_rx_hunting, o_rx_rate_sel, rate_s, id2, id1};
  wire [31:0] rd_mux   = hit_ctrl ? {27'h0000000, ctrl_q} :
                         hit_stat ? stat_w :
                         hit_txw  ? {12'h000, o_tx_word} : 32'h00000000;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
      ctrl_q    <= sdp_pkg::CTRL_RST;
    end
    else
    begin
      o_pready  <= ans;
      o_pslverr <= ans & ~mapped;
      o_prdata  <= (ans & ~i_pwrite) ? rd_mux : 32'h00000000;
      if (wr_ctrl)
        ctrl_q <= i_pwdata[sdp_pkg::CTRL_W-1:0];
    end
  end

  chk_scan_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rx_locked |=> $stable(o_rx_rate_sel))
    else $error("rate changed while locked");

  chk_scan_enabled: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(o_rx_rate_sel) |-> $past(dwell_end) &&
      (($past(rate_s) & (3'h1 << o_rx_rate_sel)) != 3'h0))
    else $error("hunt moved to a disabled rate or early");

  chk_scan_sync: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ##2 (rate_s == $past(i_rate_scan_en, 2)))
    else $error("scan enables not two stages late");

  chk_sd8_lsbs: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (take20 && sd8_s && sd_mode) |=> (o_tx_word[9:2] == $past(pdw_d_q[9:2])) &&
      (o_tx_word[1:0] == ((o_tx_word[9:2] == sdp_pkg::SD8_ONES) ?
                          sdp_pkg::SD8_LSB_TRS : sdp_pkg::SD8_LSB_PAD)))
    else $error("8-bit SD low bits wrong");

  chk_sd8_ones: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (take10 && !first10 && sd8_s && sd_src[9:2] == sdp_pkg::SD8_ONES)
      |=> (o_tx_word[11:10] == sdp_pkg::SD8_LSB_TRS))
    else $error("all-ones SD word not padded with ones");

  chk_trs_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_tx_trs |-> (o_tx_high_def && o_tx_word_vld && $past(ins_any)))
    else $error("timing marker passed in SD or with insertions off");

  chk_tx_capture: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (take20 && !sd_mode) |=> (o_tx_word_vld && o_tx_word == $past(pdw_d_q)))
    else $error("parallel word not captured on clock edge");

  chk_sd_port: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (sd10 && sdport && c27_rise && !first10) |=> (o_tx_word_vld && o_tx_word[19:10] == $past(sd_exp)))
    else $error("dedicated SD word not captured on SD clock");

  chk_s2_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_rx_level_b |=> !o_ident_ok_s2)
    else $error("stream two flag outside level-B");

  chk_apb_ready: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ans |=> o_pready ##1 !o_pready)
    else $error("APB answer not exactly one cycle");

  cov_lock_hold: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    i_rx_locked && $fell(rate_s[o_rx_rate_sel]));
  cov_sd_pair: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    take10 && first10 ##[1:40] take10 && !first10);
  cov_id_line: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(o_ident_line_right_s2));

endmodule : sdp_ports

// ### sdp_sync.sv
/*
  Two-stage synchroniser for a bus of independent levels.
  Assumes each bit is a level or a slow pulse relative to i_clk.
*/
`timescale 1ns/1ns
module sdp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= '0;
      o_q    <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule : sdp_sync

// ### sdp_tx_src.sv
/*
  Model of the user video source on the transmit pins.
  Assumes one call of send per word; its clock idles between words.
*/
`timescale 1ns/1ns
module sdp_tx_src (
  output logic        o_pdi_clk,
  output logic        o_half,
  output logic        o_c27,
  output logic [19:0] o_word,
  output logic [9:0]  o_sdw,
  output logic        o_trs,
  output logic        o_hd,
  output logic        o_sd8
);
  initial
  begin
    o_pdi_clk = 1'b0;
    o_half    = 1'b0;
    o_c27     = 1'b0;
    o_word    = 20'h00000;
    o_sdw     = 10'h000;
    o_trs     = 1'b0;
    o_hd      = 1'b1;
    o_sd8     = 1'b0;
  end
  // Data stands 80 ns each side of the rise, then shows its inverse;
  // the SD port carries the upper half so that its selection is visible
  task automatic send(input logic [19:0] w, input logic t, input logic h, input logic e,
                      input logic f);
    #1;
    o_word = w;
    o_sdw  = w[19:10];
    o_half = f;
    o_trs  = t;
    o_hd   = h;
    o_sd8  = e;
    #80 o_pdi_clk = 1'b1;
    o_c27  = 1'b1;
    #80 o_pdi_clk = 1'b0;
    o_c27  = 1'b0;
    o_word = ~w;
    o_sdw  = ~w[19:10];
    o_trs  = 1'b0;
  endtask : send
endmodule : sdp_tx_src

// ### test_sdp_ports.sv
/*
  Self-checking bench for the video PHY user-side ports.
  Assumes the source model drives the transmit pins.
*/
`timescale 1ns/1ns
module test_sdp_ports;
  localparam int DW = 16;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        vld    = 1'b0;
  logic [9:0]  w1     = 10'h000;
  logic [9:0]  w2     = 10'h000;
  logic [10:0] ln     = 11'h000;
  logic        lvb    = 1'b0;
  logic        lock   = 1'b0;
  logic [2:0]  scan   = 3'h0;
  logic        il     = 1'b0;
  logic        pdi, trs, hd, sd8, pready, pslverr, hunt, txv, txt, txh, txl, half, c27;
  logic [9:0]  sdw;
  logic        ok1, sf1, pf1, lr1, ok2, sf2, pf2, lr2;
  logic [19:0] pw, txw;
  logic [31:0] prdata;
  logic [1:0]  rate;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          cyc         = 0;

  always #4 clk = ~clk;

  sdp_tx_src sdp_tx_src_i (.o_pdi_clk(pdi), .o_half(half), .o_c27(c27), .o_word(pw),
    .o_sdw(sdw), .o_trs(trs), .o_hd(hd), .o_sd8(sd8));

  sdp_ports #(.DWELL(DW)) sdp_ports_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_rx_word_vld(vld), .i_rx_s1_word(w1), .i_rx_s2_word(w2),
    .i_rx_s1_line(ln), .i_rx_s2_line(ln), .i_rx_interlaced(il), .i_rx_level_b(lvb),
    .i_rx_locked(lock), .i_rate_scan_en(scan), .o_rx_rate_sel(rate), .o_rx_hunting(hunt),
    .o_ident_ok_s1(ok1), .o_ident_sum_fault_s1(sf1), .o_ident_par_fault_s1(pf1),
    .o_ident_line_right_s1(lr1), .o_ident_ok_s2(ok2), .o_ident_sum_fault_s2(sf2),
    .o_ident_par_fault_s2(pf2), .o_ident_line_right_s2(lr2), .i_pdi_clk(pdi),
    .i_tx_half_clk(half), .i_sd_27m_clock(c27), .i_tx_parallel_word(pw),
    .i_tx_sd_ten_bit_word(sdw), .i_trs_marker(trs), .i_high_def_select(hd),
    .i_level_b_select(lvb), .i_sd_eight_bit_select(sd8), .o_tx_word(txw),
    .o_tx_word_vld(txv), .o_tx_trs(txt), .o_tx_high_def(txh), .o_tx_level_b(txl));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic t_apb;
    logic [31:0] r;
    logic        e;
    apb(1'b0, sdp_pkg::REG_CTRL, 32'h0, r, e);
    chk("ctrl", {27'h0, sdp_pkg::CTRL_RST}, r);
    chk("ctrl_err", 32'h0, {31'h0, e});
    apb(1'b1, 8'hFC, 32'hFFFFFFFF, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("done apb");
  endtask : t_apb

  task automatic t_hunt;
    logic [1:0] r;
    scan <= 3'h4;
    repeat (8 * DW) @(posedge clk);
    chk("rate", 32'h6, {29'h0, hunt, rate});
    scan <= 3'h3;
    repeat (4 * DW) @(posedge clk);
    repeat (6 * DW)
    begin
      @(posedge clk);
      chk("rate_off", 32'h0, {31'h0, rate === 2'h2});
    end
    lock <= 1'b1;
    repeat (2) @(posedge clk);
    r = rate;
    scan <= 3'h0;
    repeat (40) @(posedge clk);
    chk("rate_hold", {30'h0, r}, {29'h0, hunt, rate});
    $display("done hunt");
  endtask : t_hunt

  task automatic tx(input logic [19:0] w, input logic t, input logic h, input logic e,
                    input logic p, input logic [21:0] x);
    int n;
    n = 0;
    if (p)
      sdp_tx_src_i.send(w, t, h, e, 1'b1);
    fork
      sdp_tx_src_i.send(p ? {w[9:0], w[19:10]} : w, t, h, e, 1'b0);
      begin
        do
          @(posedge clk);
        while (txv !== 1'b1 && ++n < 40);
        chk("tx", {10'h0, x}, {10'h0, txt, txh, txw});
        chk("tx_lvb", {31'h0, lvb}, {31'h0, txl});
      end
    join
    @(posedge clk);
  endtask : tx

  task automatic t_tx;
    logic [31:0] r;
    logic        e;
    tx(20'hFFFFF, 1'b1, 1'b1, 1'b0, 1'b0, {2'h3, 20'hFFFFF});
    tx({10'h3FE, 10'h283}, 1'b1, 1'b0, 1'b1, 1'b0, {2'h0, 20'hFFE80});
    lvb <= 1'b1;
    tx(20'h12345, 1'b0, 1'b1, 1'b1, 1'b0, {2'h1, 20'h12345});
    lvb <= 1'b0;
    apb(1'b1, sdp_pkg::REG_CTRL, 32'h0, r, e);
    tx(20'hABCDE, 1'b1, 1'b1, 1'b0, 1'b0, {2'h1, 20'hABCDE});
    apb(1'b0, sdp_pkg::REG_TXW, 32'h0, r, e);
    chk("txw", 32'h000ABCDE, r);
    apb(1'b1, sdp_pkg::REG_CTRL, 32'h1, r, e);
    tx(20'hFF5C6, 1'b0, 1'b0, 1'b1, 1'b1, {2'h0, 20'hFFDC4});
    apb(1'b1, sdp_pkg::REG_CTRL, 32'h3, r, e);
    tx(20'h5A3C7, 1'b0, 1'b0, 1'b0, 1'b1, {2'h0, 20'hF1D68});
    $display("done tx");
  endtask : t_tx

  function automatic logic [9:0] enc(input logic [7:0] b);
    enc = {~^b, ^b, b};
  endfunction : enc

  task automatic pkt(input logic s2, input logic [10:0] l, input logic bs, input logic bp);
    logic [9:0] w[11];
    logic [8:0] s;
    w = '{10'h000, 10'h3FF, 10'h3FF, sdp_pkg::ID_DID, sdp_pkg::ID_SDID, enc(8'h04),
          enc(8'h89), enc(8'h0A), enc(8'h20), enc(8'h01), 10'h000};
    w[6][8] = w[6][8] ^ bp;
    s = 9'h000;
    for (int i = 3; i < 10; i++)
      s = s + w[i][8:0];
    w[10] = {~s[8], s ^ {8'h00, bs}};
    ln <= l;
    for (int i = 0; i < 11; i++)
    begin
      w1  <= s2 ? 10'h000 : w[i];
      w2  <= s2 ? w[i] : 10'h000;
      vld <= 1'b1;
      @(posedge clk);
    end
    vld <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ident", {28'h0, il ? (l == 11'h23C) : (l == 11'h00A), bp, bs, 1'b1},
        s2 ? {28'h0, lr2, pf2, sf2, ok2} : {28'h0, lr1, pf1, sf1, ok1});
  endtask : pkt

  task automatic t_ident;
    pkt(1'b0, 11'h00A, 1'b0, 1'b0);
    pkt(1'b0, 11'h00B, 1'b1, 1'b0);
    il <= 1'b1;
    pkt(1'b0, 11'h00A, 1'b0, 1'b0);
    pkt(1'b0, 11'h23C, 1'b0, 1'b0);
    il <= 1'b0;
    pkt(1'b0, 11'h00A, 1'b0, 1'b1);
    lvb <= 1'b1;
    pkt(1'b1, 11'h00A, 1'b1, 1'b0);
    chk("s1_hold", 32'hD, {28'h0, lr1, pf1, sf1, ok1});
    $display("done ident");
  endtask : t_ident

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_apb();
    t_hunt();
    t_tx();
    t_ident();
    report_and_stop();
  end
endmodule : test_sdp_ports
